// *** design/nap_top.sv ***
// Access gate for program flash and data EEPROM, with APB registers.
// Assumes a memory port that holds a request until it pulses done, an
// external programmer that drops its request after the acknowledge, and
// configuration inputs that are stable around the release of reset.
//
// The register addresses and the APB interface to the registers were left to the implementer.

// Overview of operation
// - With the program protect bit at 0, external program writes are dropped and reads give zero.
// - CPU reads of program memory run whatever the protect bits say.
// - Of the configuration inputs, only the guard size setting decides whether a CPU program write may go.
// - With the EEPROM protect bit at 0, external EEPROM reads and writes are blocked.
// - The CPU can always read and write the data EEPROM.
// - Each memory's external access is judged only by its own protect bit.
// - A two-bit guard size picks a low program block whose self-writes are suppressed.
// - Four user ID words are readable and writable during normal running.
// - The start bit reads set while a write runs and clears when it completes.
module nap_top
  import nap_pkg::*;
(
  input wire logic pclk,                 // Core clock, 250 MHz.
  input wire logic presetn,              // Asynchronous reset, active low.
  input wire logic [7:0] paddr,          // APB byte address.
  input wire logic psel,                 // APB select.
  input wire logic penable,              // APB access phase.
  input wire logic pwrite,               // APB write when high.
  input wire logic [31:0] pwdata,        // APB write data.
  output logic [31:0] prdata,            // APB read data.
  output logic pready,                   // APB ready.
  output logic pslverr,                  // APB error on unmapped address.
  input wire logic cfg_program_read_protect, // Program protect, 0 guards.
  input wire logic cfg_eeprom_read_protect,  // EEPROM protect, 0 guards.
  input wire logic [1:0] cfg_self_write_guard_size, // Guard size code.
  input wire logic ext_req,              // Programmer request, level.
  input wire logic ext_we,               // Programmer write when high.
  input wire logic ext_ee,               // Programmer targets EEPROM.
  input wire logic [NAP_AW-1:0] ext_addr, // Programmer word address.
  input wire logic [NAP_DW-1:0] ext_wdata, // Programmer write data.
  output logic [NAP_DW-1:0] ext_rdata,   // Programmer read data.
  output logic ext_ack,                  // Programmer acknowledge pulse.
  output logic ext_denied,               // Last external access refused.
  output logic nvm_req,                  // Memory request, level.
  output logic nvm_we,                   // Memory write when high.
  output logic nvm_ee,                   // Memory targets EEPROM.
  output logic [NAP_AW-1:0] nvm_addr,    // Memory word address.
  output logic [NAP_DW-1:0] nvm_wdata,   // Memory write data.
  input wire logic [NAP_DW-1:0] nvm_rdata, // Memory read data.
  input wire logic nvm_done              // Memory done pulse.
);

  nap_op_if op ();

  nap_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .op(op)
  );

  // Latched configuration.
  logic cfg_loaded_reg;
  logic pprot_reg;
  logic eprot_reg;
  logic [1:0] guard_reg;

  // Software-visible state.
  logic write_enable_bit_reg, write_enable_bit_next;
  logic ee_sel_reg, ee_sel_next;
  logic werr_reg, werr_next;
  logic [NAP_AW-1:0] addr_reg, addr_next;
  logic [NAP_DW-1:0] data_reg, data_next;
  logic [NAP_DW-1:0] id_reg [NAP_ID_WORDS];
  logic [31:0] prdata_reg, prdata_next;

  // Memory port owner and its outputs.
  nap_own_t own_reg, own_next;
  logic nvm_req_reg, nvm_req_next;
  logic nvm_we_reg, nvm_we_next;
  logic nvm_ee_reg, nvm_ee_next;
  logic [NAP_AW-1:0] nvm_addr_reg, nvm_addr_next;
  logic [NAP_DW-1:0] nvm_wdata_reg, nvm_wdata_next;
  logic [NAP_DW-1:0] ext_rdata_reg, ext_rdata_next;
  logic ext_denied_reg, ext_denied_next;

  // APB decode.
  wire logic setup = psel && !penable;
  wire logic access = psel && penable;
  wire logic wr = access && pwrite;
  wire logic hit_ctrl = paddr == NAP_OFS_CTRL;
  wire logic hit_unlock = paddr == NAP_OFS_UNLOCK;
  wire logic hit_addr = paddr == NAP_OFS_ADDR;
  wire logic hit_data = paddr == NAP_OFS_DATA;
  wire logic hit_stat = paddr == NAP_OFS_STAT;
  wire logic hit_id = (paddr & NAP_OFS_ID_MASK) == NAP_OFS_ID0;
  wire logic hit_any = hit_ctrl || hit_unlock || hit_addr || hit_data ||
                       hit_stat || hit_id;
  wire logic [1:0] id_idx = paddr[3:2];
  wire logic busy = op.wr_busy || op.rd_busy;
  wire logic wr_ctrl = wr && hit_ctrl;

  // External access judgement.
  wire logic ext_block = nap_ext_blocked(ext_ee, pprot_reg, eprot_reg);

  // Settings are taken on the first edge after reset release only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_loaded_reg <= 1'b0;
      pprot_reg <= NAP_PROT_RST;
      eprot_reg <= NAP_PROT_RST;
      guard_reg <= NAP_GUARD_RST;
    end else if (!cfg_loaded_reg) begin
      cfg_loaded_reg <= 1'b1;
      pprot_reg <= cfg_program_read_protect;
      eprot_reg <= cfg_eeprom_read_protect;
      guard_reg <= cfg_self_write_guard_size;
    end
  end

  // Register writes; address and data hold still while an access runs.
  always_comb begin
    write_enable_bit_next = write_enable_bit_reg;
    ee_sel_next = ee_sel_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    werr_next = werr_reg;
    if (wr_ctrl) begin
      write_enable_bit_next = pwdata[NAP_CTRL_WRITE_ENABLE_BIT];
      if (!busy) begin
        ee_sel_next = pwdata[NAP_CTRL_EESEL];
      end
      if (pwdata[NAP_CTRL_WERR]) begin
        werr_next = 1'b0;
      end
    end
    if (wr && hit_addr && !busy) begin
      addr_next = pwdata[NAP_AW-1:0];
    end
    if (wr && hit_data && !busy) begin
      data_next = pwdata[NAP_DW-1:0];
    end
    if (own_reg == NAP_OWN_CPU && nvm_done && !nvm_we_reg) begin
      data_next = nvm_rdata;
    end
    // A guard hit in the clearing cycle still leaves the flag set.
    if (op.guard_hit) begin
      werr_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_enable_bit_reg <= 1'b0;
      ee_sel_reg <= 1'b0;
      werr_reg <= 1'b0;
      addr_reg <= '0;
      data_reg <= '0;
    end else begin
      write_enable_bit_reg <= write_enable_bit_next;
      ee_sel_reg <= ee_sel_next;
      werr_reg <= werr_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
    end
  end

  // User ID words are plain storage open to software at all times.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NAP_ID_WORDS; i++) begin
        id_reg[i] <= '0;
      end
    end else if (wr && hit_id) begin
      id_reg[id_idx] <= pwdata[NAP_DW-1:0];
    end
  end

  // Read data is taken in the setup cycle, so the access needs no wait.
  always_comb begin
    prdata_next = prdata_reg;
    if (setup) begin
      prdata_next = '0;
      if (hit_ctrl) begin
        prdata_next[NAP_CTRL_WRITE_ENABLE_BIT] = write_enable_bit_reg;
        prdata_next[NAP_CTRL_START] = op.wr_busy;
        prdata_next[NAP_CTRL_READ] = op.rd_busy;
        prdata_next[NAP_CTRL_EESEL] = ee_sel_reg;
        prdata_next[NAP_CTRL_WERR] = werr_reg;
      end else if (hit_addr) begin
        prdata_next[NAP_AW-1:0] = addr_reg;
      end else if (hit_data) begin
        prdata_next[NAP_DW-1:0] = data_reg;
      end else if (hit_stat) begin
        prdata_next[NAP_STAT_PPROT] = pprot_reg;
        prdata_next[NAP_STAT_EPROT] = eprot_reg;
        prdata_next[NAP_STAT_GUARD +: 2] = guard_reg;
        prdata_next[NAP_STAT_EXTDN] = ext_denied_reg;
      end else if (hit_id) begin
        prdata_next[NAP_DW-1:0] = id_reg[id_idx];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = access && !hit_any;

  // Sequencer requests.
  assign op.write_enable_bit = write_enable_bit_reg;
  assign op.key_wr = wr && hit_unlock;
  assign op.key_data = pwdata[7:0];
  assign op.start_req = wr_ctrl && pwdata[NAP_CTRL_START];
  assign op.read_req = wr_ctrl && pwdata[NAP_CTRL_READ];
  assign op.to_ee = ee_sel_reg;
  assign op.addr = addr_reg;
  assign op.guard = guard_reg;
  assign op.mem_gnt = own_reg == NAP_OWN_NONE && op.mem_req;
  assign op.mem_done = own_reg == NAP_OWN_CPU && nvm_done;

  // Memory port owner. The CPU wins a tie and is never checked against
  // the protect bits; external accesses are judged per target memory.
  always_comb begin
    own_next = own_reg;
    nvm_req_next = nvm_req_reg;
    nvm_we_next = nvm_we_reg;
    nvm_ee_next = nvm_ee_reg;
    nvm_addr_next = nvm_addr_reg;
    nvm_wdata_next = nvm_wdata_reg;
    ext_rdata_next = ext_rdata_reg;
    ext_denied_next = ext_denied_reg;
    unique case (own_reg)
      NAP_OWN_NONE: begin
        if (op.mem_req) begin
          own_next = NAP_OWN_CPU;
          nvm_req_next = 1'b1;
          nvm_we_next = op.mem_we;
          nvm_ee_next = op.mem_ee;
          nvm_addr_next = addr_reg;
          nvm_wdata_next = data_reg;
        end else if (ext_req && ext_block) begin
          own_next = NAP_OWN_ACK;
          ext_rdata_next = '0;
          ext_denied_next = 1'b1;
        end else if (ext_req) begin
          own_next = NAP_OWN_EXT;
          ext_denied_next = 1'b0;
          nvm_req_next = 1'b1;
          nvm_we_next = ext_we;
          nvm_ee_next = ext_ee;
          nvm_addr_next = ext_addr;
          nvm_wdata_next = ext_wdata;
        end
      end
      NAP_OWN_CPU: begin
        if (nvm_done) begin
          own_next = NAP_OWN_NONE;
          nvm_req_next = 1'b0;
        end
      end
      NAP_OWN_EXT: begin
        if (nvm_done) begin
          own_next = NAP_OWN_ACK;
          nvm_req_next = 1'b0;
          ext_rdata_next = nvm_we_reg ? '0 : nvm_rdata;
        end
      end
      NAP_OWN_ACK: begin
        own_next = NAP_OWN_NONE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_reg <= NAP_OWN_NONE;
      nvm_req_reg <= 1'b0;
      nvm_we_reg <= 1'b0;
      nvm_ee_reg <= 1'b0;
      nvm_addr_reg <= '0;
      nvm_wdata_reg <= '0;
      ext_rdata_reg <= '0;
      ext_denied_reg <= 1'b0;
    end else begin
      own_reg <= own_next;
      nvm_req_reg <= nvm_req_next;
      nvm_we_reg <= nvm_we_next;
      nvm_ee_reg <= nvm_ee_next;
      nvm_addr_reg <= nvm_addr_next;
      nvm_wdata_reg <= nvm_wdata_next;
      ext_rdata_reg <= ext_rdata_next;
      ext_denied_reg <= ext_denied_next;
    end
  end

  assign nvm_req = nvm_req_reg;
  assign nvm_we = nvm_we_reg;
  assign nvm_ee = nvm_ee_reg;
  assign nvm_addr = nvm_addr_reg;
  assign nvm_wdata = nvm_wdata_reg;
  assign ext_rdata = ext_rdata_reg;
  assign ext_ack = own_reg == NAP_OWN_ACK;
  assign ext_denied = ext_denied_reg;

endmodule

// *** inc/nap_pkg.sv ***
// Constants, register map and state types of the nonvolatile access gate.
// Assumes a 250 MHz APB clock and a word-wide memory port behind the gate.
package nap_pkg;

  localparam int NAP_AW = 15;
  localparam int NAP_DW = 14;

  // Register byte offsets on the APB side.
  localparam logic [7:0] NAP_OFS_CTRL = 8'h00;
  localparam logic [7:0] NAP_OFS_UNLOCK = 8'h04;
  localparam logic [7:0] NAP_OFS_ADDR = 8'h08;
  localparam logic [7:0] NAP_OFS_DATA = 8'h0C;
  localparam logic [7:0] NAP_OFS_STAT = 8'h10;
  localparam logic [7:0] NAP_OFS_ID0 = 8'h20;
  localparam logic [7:0] NAP_OFS_ID_MASK = 8'hF0;
  localparam int NAP_ID_WORDS = 4;

  // Control register fields.
  localparam int NAP_CTRL_WRITE_ENABLE_BIT = 0;
  localparam int NAP_CTRL_START = 1;
  localparam int NAP_CTRL_READ = 2;
  localparam int NAP_CTRL_EESEL = 3;
  localparam int NAP_CTRL_WERR = 4;

  // Status register fields.
  localparam int NAP_STAT_PPROT = 0;
  localparam int NAP_STAT_EPROT = 1;
  localparam int NAP_STAT_GUARD = 2;
  localparam int NAP_STAT_EXTDN = 4;

  localparam logic [7:0] NAP_KEY_FIRST = 8'h55;
  localparam logic [7:0] NAP_KEY_SECOND = 8'hAA;

  // Self-write guard size codes and the top of each guarded block.
  localparam logic [1:0] NAP_GUARD_OFF = 2'b11;
  localparam logic [1:0] NAP_GUARD_SMALL = 2'b10;
  localparam logic [1:0] NAP_GUARD_HALF = 2'b01;
  localparam logic [1:0] NAP_GUARD_ALL = 2'b00;
  localparam logic [NAP_AW-1:0] NAP_LIM_SMALL = 15'h0200;
  localparam logic [NAP_AW-1:0] NAP_LIM_HALF = 15'h2000;
  localparam logic [NAP_AW-1:0] NAP_LIM_ALL = 15'h4000;

  // Reset values: protected until the configuration is latched.
  localparam logic NAP_PROT_RST = 1'b0;
  localparam logic [1:0] NAP_GUARD_RST = 2'b00;

  typedef enum logic [2:0] {
    NAP_SEQ_IDLE = 3'b001,
    NAP_SEQ_REQ = 3'b010,
    NAP_SEQ_WAIT = 3'b100
  } nap_seq_t;

  typedef enum logic [2:0] {
    NAP_KEY_LOCKED = 3'b001,
    NAP_KEY_HALF = 3'b010,
    NAP_KEY_OPEN = 3'b100
  } nap_key_t;

  typedef enum logic [3:0] {
    NAP_OWN_NONE = 4'b0001,
    NAP_OWN_CPU = 4'b0010,
    NAP_OWN_EXT = 4'b0100,
    NAP_OWN_ACK = 4'b1000
  } nap_own_t;

  // True when a program-memory write at addr falls in the guarded block.
  function automatic logic nap_guarded(input logic [1:0] g,
                                       input logic to_ee,
                                       input logic [NAP_AW-1:0] addr);
    logic hit;
    hit = 1'b0;
    if (!to_ee) begin
      unique case (g)
        NAP_GUARD_OFF: hit = 1'b0;
        NAP_GUARD_SMALL: hit = addr < NAP_LIM_SMALL;
        NAP_GUARD_HALF: hit = addr < NAP_LIM_HALF;
        NAP_GUARD_ALL: hit = addr < NAP_LIM_ALL;
      endcase
    end
    return hit;
  endfunction

  // An external access is refused when its own memory's protect bit is 0.
  function automatic logic nap_ext_blocked(input logic to_ee,
                                           input logic pprot,
                                           input logic eprot);
    return to_ee ? !eprot : !pprot;
  endfunction

endpackage

// *** inc/nap_op_if.sv ***
// Link between the register block and the self-access sequencer.
// Assumes both ends sit on the same pclk.
interface nap_op_if;
  import nap_pkg::*;
  logic write_enable_bit;
  logic key_wr;
  logic [7:0] key_data;
  logic start_req;
  logic read_req;
  logic to_ee;
  logic [NAP_AW-1:0] addr;
  logic [1:0] guard;
  logic wr_busy;
  logic rd_busy;
  logic guard_hit;
  logic mem_req;
  logic mem_we;
  logic mem_ee;
  logic mem_gnt;
  logic mem_done;

  modport regs (output write_enable_bit, key_wr, key_data, start_req, read_req, to_ee,
                addr, guard, mem_gnt, mem_done,
                input wr_busy, rd_busy, guard_hit, mem_req, mem_we, mem_ee);
  modport seq (input write_enable_bit, key_wr, key_data, start_req, read_req, to_ee,
               addr, guard, mem_gnt, mem_done,
               output wr_busy, rd_busy, guard_hit, mem_req, mem_we, mem_ee);
endinterface

// *** design/nap_seq.sv ***
// Self-access sequencer: unlock key, write start, guard check, polling.
// Assumes the register block grants the memory port and reports done.
module nap_seq
  import nap_pkg::*;
(
  input wire logic pclk,    // Core clock.
  input wire logic presetn, // Asynchronous reset, active low.
  nap_op_if.seq op          // Requests from and answers to the registers.
);

  nap_seq_t seq_reg, seq_next;
  nap_key_t key_reg, key_next;
  logic we_reg, we_next;
  logic ee_reg, ee_next;
  logic hit_reg, hit_next;

  wire logic idle = seq_reg == NAP_SEQ_IDLE;
  wire logic armed = op.write_enable_bit && key_reg == NAP_KEY_OPEN;
  wire logic guard_now = nap_guarded(op.guard, op.to_ee, op.addr);
  wire logic go_wr = idle && op.start_req && armed && !guard_now;
  wire logic go_rd = idle && op.read_req && !op.start_req;

  always_comb begin
    key_next = key_reg;
    if (!op.write_enable_bit || (idle && op.start_req)) begin
      key_next = NAP_KEY_LOCKED;
    end else if (op.key_wr) begin
      if (op.key_data == NAP_KEY_FIRST) begin
        key_next = NAP_KEY_HALF;
      end else if (key_reg == NAP_KEY_HALF &&
                   op.key_data == NAP_KEY_SECOND) begin
        key_next = NAP_KEY_OPEN;
      end else begin
        key_next = NAP_KEY_LOCKED;
      end
    end
  end

  always_comb begin
    seq_next = seq_reg;
    we_next = we_reg;
    ee_next = ee_reg;
    hit_next = idle && op.start_req && armed && guard_now;
    unique case (seq_reg)
      NAP_SEQ_IDLE: begin
        if (go_wr || go_rd) begin
          seq_next = NAP_SEQ_REQ;
          we_next = go_wr;
          ee_next = op.to_ee;
        end
      end
      NAP_SEQ_REQ: begin
        if (op.mem_gnt) begin
          seq_next = NAP_SEQ_WAIT;
        end
      end
      NAP_SEQ_WAIT: begin
        if (op.mem_done) begin
          seq_next = NAP_SEQ_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= NAP_SEQ_IDLE;
      key_reg <= NAP_KEY_LOCKED;
      we_reg <= 1'b0;
      ee_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      key_reg <= key_next;
      we_reg <= we_next;
      ee_reg <= ee_next;
      hit_reg <= hit_next;
    end
  end

  assign op.wr_busy = !idle && we_reg;
  assign op.rd_busy = !idle && !we_reg;
  assign op.guard_hit = hit_reg;
  assign op.mem_req = seq_reg == NAP_SEQ_REQ;
  assign op.mem_we = we_reg;
  assign op.mem_ee = ee_reg;

endmodule

// *** sim/nap_assertions.sv ***
// Checker for the access gate, bound to the top module's ports.
// Assumes protect settings are latched at the first edge after reset.
module nap_assertions
  import nap_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic [7:0] paddr, // APB address.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pready, // APB ready.
  input wire logic pslverr, // APB error.
  input wire logic cfg_program_read_protect, // Program protect.
  input wire logic cfg_eeprom_read_protect, // EEPROM protect.
  input wire logic ext_ee, // Programmer targets EEPROM.
  input wire logic [NAP_DW-1:0] ext_rdata, // Programmer read data.
  input wire logic ext_ack, // Programmer acknowledge.
  input wire logic ext_denied, // Programmer refused.
  input wire logic nvm_req, // Memory request.
  input wire logic nvm_we, // Memory write.
  input wire logic nvm_ee, // Memory targets EEPROM.
  input wire logic [NAP_AW-1:0] nvm_addr, // Memory address.
  input wire logic nvm_done // Memory done.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic seen_reg, pp_reg, ep_reg;
  wire unmapped = paddr inside {8'h14, 8'h18, 8'h1C} || paddr >= 8'h30;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= 1'b0;
      pp_reg <= 1'b0;
      ep_reg <= 1'b0;
    end else if (!seen_reg) begin
      seen_reg <= 1'b1;
      pp_reg <= cfg_program_read_protect;
      ep_reg <= cfg_eeprom_read_protect;
    end
  end
  sequence s_mem_end; nvm_req && nvm_done; endsequence
  sequence s_ext_ok; ext_ack && !ext_denied; endsequence
  property p_ready; psel |-> pready; endproperty
  a_ready: assert property (p_ready)
    else $error("pready low in a transfer");
  property p_slverr; psel && penable |-> pslverr == unmapped; endproperty
  a_slverr: assert property (p_slverr)
    else $error("pslverr does not follow the address map");
  property p_prog_deny;
    ext_ack && !ext_ee && !pp_reg |-> ext_denied && ext_rdata == '0;
  endproperty
  a_prog_deny: assert property (p_prog_deny)
    else $error("protected program access not refused");
  property p_ee_deny; ext_ack && ext_ee && !ep_reg |-> ext_denied; endproperty
  a_ee_deny: assert property (p_ee_deny)
    else $error("protected eeprom access not refused");
  property p_indep;
    ext_ack |-> ext_denied == (ext_ee ? !ep_reg : !pp_reg);
  endproperty
  a_indep: assert property (p_indep)
    else $error("refusal not judged by the target protect bit");
  property p_ack_pulse; ext_ack |=> !ext_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("acknowledge longer than one cycle");
  property p_mem_hold;
    nvm_req && !nvm_done |=> nvm_req && $stable({nvm_addr, nvm_we, nvm_ee});
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request dropped or changed early");
  property p_mem_drop; s_mem_end |=> !nvm_req; endproperty
  a_mem_drop: assert property (p_mem_drop)
    else $error("memory request held after done");
  property p_ext_ok; s_ext_ok |-> $past(nvm_done); endproperty
  a_ext_ok: assert property (p_ext_ok)
    else $error("allowed acknowledge without memory done");
endmodule

// *** sim/nap_mem_model.sv ***
// Behavioural program flash and EEPROM behind the gate's memory port.
// Assumes requests are held until done; slow stretches each answer.
module nap_mem_model
  import nap_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic nvm_req, // Request, level.
  input wire logic nvm_we, // Write when high.
  input wire logic nvm_ee, // EEPROM when high.
  input wire logic [NAP_AW-1:0] nvm_addr, // Word address.
  input wire logic [NAP_DW-1:0] nvm_wdata, // Write data.
  input wire logic slow, // Answer late when high.
  output logic [NAP_DW-1:0] nvm_rdata, // Read data.
  output logic nvm_done // Done pulse.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [NAP_DW-1:0] mem [int];
  int wait_cnt;
  int key;
  assign key = int'({nvm_ee, nvm_addr});
  // Contents survive reset; read data toggles between answers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 0;
      nvm_done <= 1'b0;
      nvm_rdata <= '0;
    end else begin
      nvm_done <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
      if (nvm_req && !nvm_done) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt >= (slow ? 5 : 0)) begin
          wait_cnt <= 0;
          nvm_done <= 1'b1;
          nvm_rdata <= mem.exists(key) ? mem[key] : '0;
          if (nvm_we)
            mem[key] = nvm_wdata;
        end
      end
    end
  end
endmodule

// *** sim/nap_top_test.sv ***
// Self-checking bench: APB master, programmer driver and memory model.
// Assumes the checker and memory model files are compiled first.
module nap_top_test
  import nap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [NAP_AW-1:0] edge_addr [5] =
    '{15'h01FF, 15'h0200, 15'h1FFF, 15'h2000, 15'h3FFF};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, ext_ack, ext_denied, err_s;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic cfg_program_read_protect = 1'b1, cfg_eeprom_read_protect = 1'b1;
  logic [1:0] cfg_self_write_guard_size = 2'b11, lgs;
  logic ext_req = 1'b0, ext_we = 1'b0, ext_ee = 1'b0, lpp, lep, last_den;
  logic [NAP_AW-1:0] ext_addr = '0, nvm_addr;
  logic [NAP_DW-1:0] ext_wdata = '0, ext_rdata, nvm_wdata, nvm_rdata;
  logic nvm_req, nvm_we, nvm_ee, nvm_done, slow = 1'b0;
  int n_fail = 0, compares = 0, seed = 99226, cycles = 0;
  logic [NAP_DW-1:0] model [int];
  always #2 pclk = ~pclk;
  nap_top dut_u (.*);
  nap_mem_model mem_u (.*);
  task automatic give_verdict();
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ext(input logic [15:0] got, input logic [15:0] exp);
    chk_reg({16'h0000, got}, {16'h0000, exp});
  endtask
  function automatic logic [NAP_DW-1:0] mval(input logic ee,
                                             input logic [NAP_AW-1:0] a);
    return model.exists(int'({ee, a})) ? model[int'({ee, a})] : '0;
  endfunction
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, rd);
  endtask
  task automatic rdr(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0000_0000, rd);
    chk_reg(rd, e);
  endtask
  task automatic poll();
    int n = 0;
    do apb(NAP_OFS_CTRL, 1'b0, 32'h0000_0000, rd);
    while (rd[2:1] !== 2'b00 && n++ < 200);
  endtask
  task automatic ext_op(input logic we, input logic ee,
                        input logic [NAP_AW-1:0] a);
    logic [NAP_DW-1:0] d;
    logic den;
    int n = 0;
    d = NAP_DW'($random(seed));
    den = ee ? !lep : !lpp;
    @(posedge pclk);
    slow <= 1'($random(seed));
    ext_req <= 1'b1;
    ext_we <= we;
    ext_ee <= ee;
    ext_addr <= a;
    ext_wdata <= d;
    do @(posedge pclk); while (ext_ack !== 1'b1 && n++ < 100);
    chk_ext({ext_ack, ext_denied, ext_rdata},
            {1'b1, den, (den || we) ? {NAP_DW{1'b0}} : mval(ee, a)});
    if (!den && we)
      model[int'({ee, a})] = d;
    last_den = den;
    ext_req <= 1'b0;
    ext_we <= ~we;
    ext_addr <= ~a;
    ext_wdata <= ~d;
  endtask
  task automatic cpu_wr(input logic ee, input logic [NAP_AW-1:0] a);
    logic [NAP_DW-1:0] d;
    logic [NAP_AW-1:0] lim;
    logic hit;
    d = NAP_DW'($random(seed));
    case (lgs)
      NAP_GUARD_ALL: lim = NAP_LIM_ALL;
      NAP_GUARD_HALF: lim = NAP_LIM_HALF;
      NAP_GUARD_SMALL: lim = NAP_LIM_SMALL;
      default: lim = '0;
    endcase
    hit = !ee && a < lim;
    slow <= 1'($random(seed));
    wr(NAP_OFS_ADDR, 32'(a));
    wr(NAP_OFS_DATA, 32'(d));
    wr(NAP_OFS_CTRL, {28'h000_0000, ee, 3'b001});
    wr(NAP_OFS_UNLOCK, 32'h0000_0055);
    wr(NAP_OFS_UNLOCK, 32'h0000_00AA);
    wr(NAP_OFS_CTRL, {28'h000_0000, ee, 3'b011});
    apb(NAP_OFS_CTRL, 1'b0, 32'h0000_0000, rd);
    chk_reg(32'(rd[1]), 32'(!hit));
    poll();
    rdr(NAP_OFS_CTRL, {27'h000_0000, hit, ee, 3'b001});
    wr(NAP_OFS_CTRL, {27'h000_0001, ee, 3'b000});
    if (!hit)
      model[int'({ee, a})] = d;
  endtask
  task automatic cpu_rd(input logic ee, input logic [NAP_AW-1:0] a);
    wr(NAP_OFS_ADDR, 32'(a));
    wr(NAP_OFS_CTRL, {28'h000_0000, ee, 3'b100});
    poll();
    rdr(NAP_OFS_DATA, 32'(mval(ee, a)));
  endtask
  initial begin
    logic [NAP_AW-1:0] a;
    logic [31:0] ids [4];
    for (int k = 0; k < 4; k++) begin
      presetn <= 1'b0;
      cfg_program_read_protect <= k[0];
      cfg_eeprom_read_protect <= k[1];
      cfg_self_write_guard_size <= k[1:0];
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      lpp = k[0];
      lep = k[1];
      lgs = k[1:0];
      repeat (2) @(posedge pclk);
      {cfg_program_read_protect, cfg_eeprom_read_protect,
       cfg_self_write_guard_size} <= 4'($random(seed));
      rdr(NAP_OFS_STAT, {27'h000_0000, 1'b0, lgs, lep, lpp});
      a = NAP_AW'($random(seed)) & 15'h3FFF;
      ext_op(1'b1, 1'b0, a);
      ext_op(1'b0, 1'b0, a);
      ext_op(1'b1, 1'b1, a & 15'h00FF);
      ext_op(1'b0, 1'b1, a & 15'h00FF);
      rdr(NAP_OFS_STAT, {27'h000_0000, last_den, lgs, lep, lpp});
      foreach (edge_addr[i]) begin
        cpu_wr(1'b0, edge_addr[i]);
        cpu_rd(1'b0, edge_addr[i]);
      end
      cpu_wr(1'b1, a & 15'h00FF);
      cpu_rd(1'b1, a & 15'h00FF);
      ext_op(1'b0, 1'b0, edge_addr[4]);
      for (int i = 0; i < 4; i++) begin
        ids[i] = 32'($random(seed));
        wr(NAP_OFS_ID0 + 8'(4 * i), ids[i]);
      end
      for (int i = 0; i < 4; i++)
        rdr(NAP_OFS_ID0 + 8'(4 * i), ids[i] & 32'h0000_3FFF);
      wr(NAP_OFS_CTRL, 32'h0000_0001);
      wr(NAP_OFS_UNLOCK, 32'h0000_0055);
      wr(NAP_OFS_UNLOCK, 32'h0000_0056);
      wr(NAP_OFS_CTRL, 32'h0000_0003);
      rdr(NAP_OFS_CTRL, 32'h0000_0001);
      wr(8'h14, 32'h0000_FFFF);
      rdr(8'h30, 32'h0000_0000);
      chk_reg(32'(err_s), 32'h0000_0001);
    end
    give_verdict();
  end
endmodule
bind nap_top nap_assertions chk_u (.pclk, .presetn, .paddr, .psel, .penable,
  .pready, .pslverr, .cfg_program_read_protect, .cfg_eeprom_read_protect,
  .ext_ee, .ext_rdata, .ext_ack, .ext_denied, .nvm_req, .nvm_we, .nvm_ee,
  .nvm_addr, .nvm_done);
